// ===== design/acc_divider.sv
`timescale 1ns/1ps
// Restoring divider, one quotient bit per cycle; slow but small.
module acc_divider #(
  parameter int unsigned W = 32
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              busy,
  output logic              done,
  output logic      [W-1:0] quotient
);
  localparam int CW = $clog2(W+1);
  typedef struct packed {
    logic [W-1:0]  q;
    logic [W:0]    rem;
    logic [W-1:0]  den;
    logic [CW-1:0] cnt;
    logic          busy;
    logic          done;
  } div_st_t;
  div_st_t st_r, st_nxt;
  assign busy     = st_r.busy;
  assign done     = st_r.done;
  assign quotient = st_r.q;
  always_comb begin
    logic [W:0] trial;
    trial = '0;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start && !st_r.busy) begin
      st_nxt.q    = dividend;
      st_nxt.rem  = '0;
      st_nxt.den  = (divisor == '0) ? W'(1) : divisor;
      st_nxt.cnt  = CW'(W);
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      trial = {st_r.rem[W-1:0], st_r.q[W-1]};
      st_nxt.q = {st_r.q[W-2:0], 1'b0};
      if (trial >= {1'b0, st_r.den}) begin
        trial = trial - {1'b0, st_r.den};
        st_nxt.q[0] = 1'b1;
      end
      st_nxt.rem = trial;
      st_nxt.cnt = st_r.cnt - 1'b1;
      if (st_r.cnt == CW'(1)) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : acc_divider

// ===== design/acc_fifo.sv
`timescale 1ns/1ps
module acc_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 8
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_st_t;
  fifo_st_t st_r, st_nxt;
  logic push, pop;
  assign in_ready  = st_r.cnt != (AW+1)'(D);
  assign out_valid = st_r.cnt != '0;
  assign out_data  = st_r.mem[st_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(D-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(D-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : acc_fifo

// ===== design/signal_window_accumulator.sv
`timescale 1ns/1ps
module signal_window_accumulator #(
  parameter int unsigned NCH        = 4,
  parameter int unsigned DW         = 16,
  parameter int unsigned SW         = 32,
  parameter int unsigned WIN_CYCLES = acc_pkg::WIN_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [NCH-1:0][DW-1:0] sample_in,
  input  wire logic                  strobe_in,
  input  wire logic                  sw_strobe,
  input  wire acc_pkg::win_mode_t    win_mode,
  input  wire logic [15:0]           rate_div,
  input  wire logic [15:0]           win_count,
  input  wire logic                  avg_en,
  input  wire logic                  live_en,
  input  wire logic                  sel_wr,
  input  wire logic [7:0]            sel_wdata,
  output logic      [7:0]            sel_channel,
  input  wire logic                  thr_wr,
  input  wire logic [SW-1:0]         thr_wdata,
  output logic      [SW-1:0]         thr_level,
  input  wire logic                  global_thr,
  input  wire logic                  thr_below,
  input  wire logic                  mute,
  input  wire logic                  capture_en,
  output logic                       active,
  output logic                       done,
  output logic [NCH-1:0][SW-1:0]     strobed_result_store,
  output logic      [SW-1:0]         selected_channel_result,
  output logic                       threshold_pass_flag,
  output logic                       threshold_event_valid,
  input  wire logic                  threshold_event_ready,
  output logic      [2*SW-1:0]       threshold_event_store
);
  localparam int CH_W = $clog2(NCH) > 0 ? $clog2(NCH) : 1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DIV
  } acc_state_t;

  typedef struct packed {
    acc_state_t                state;
    logic                      strobe_d;
    logic [15:0]               rate_cnt;
    logic [31:0]               win_cnt;
    logic [31:0]               nsamp;
    logic [NCH-1:0][SW-1:0]    sum;
    logic [NCH-1:0][SW-1:0]    res;
    logic [NCH-1:0][SW-1:0]    thr;
    logic [CH_W-1:0]           div_ch;
    logic [SW-1:0]             sel_res;
    logic [7:0]                sel;
    logic                      done;
    logic                      pass_d;
    logic [31:0]               tstamp;
  } acc_st_t;

  acc_st_t st_r, st_nxt;

  logic            tick;
  logic            strobe_rise;
  logic            start_req;
  logic [CH_W-1:0] sel_idx;
  logic            div_start;
  logic            div_busy;
  logic            div_done;
  logic [SW-1:0]   div_q;
  logic            pass_raw;
  logic            ev_push;
  logic            ev_ready;

  assign tick        = st_r.rate_cnt == 16'h0000;
  assign strobe_rise = strobe_in && !st_r.strobe_d;
  assign start_req   = strobe_rise || sw_strobe;
  assign sel_idx     = CH_W'(st_r.sel);
  assign div_start   = st_r.state == ST_DIV && !div_busy && !div_done;

  acc_divider #(
    .W (SW)
  ) u_div (
    .clk      (clk),
    .srst     (srst),
    .start    (div_start),
    .dividend (st_r.sum[st_r.div_ch]),
    .divisor  (st_r.nsamp[SW-1:0]),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_q)
  );

  // Criterion evaluated on the published selected value, per channel threshold.
  assign pass_raw = thr_below ? (st_r.sel_res < st_r.thr[sel_idx])
                              : (st_r.sel_res > st_r.thr[sel_idx]);

  // Events that arrive while the FIFO is full are dropped rather than stalling the accumulator.
  assign ev_push = capture_en && pass_raw && !mute && !st_r.pass_d;

  acc_fifo #(
    .W (2*SW),
    .D (acc_pkg::FIFO_DEPTH)
  ) u_evq (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (ev_push),
    .in_ready  (ev_ready),
    .in_data   ({st_r.tstamp[SW-1:0], st_r.sel_res}),
    .out_valid (threshold_event_valid),
    .out_ready (threshold_event_ready),
    .out_data  (threshold_event_store)
  );

  always_comb begin
    logic win_end;
    win_end = 1'b0;
    st_nxt = st_r;
    st_nxt.done     = 1'b0;
    st_nxt.strobe_d = strobe_in;
    st_nxt.tstamp   = st_r.tstamp + 32'h0000_0001;
    st_nxt.pass_d   = pass_raw && !mute;
    st_nxt.rate_cnt = tick ? ((rate_div == 16'h0000) ? 16'h0000 : rate_div - 16'h0001)
                           : st_r.rate_cnt - 16'h0001;
    if (sel_wr) begin
      st_nxt.sel = sel_wdata;
    end
    if (thr_wr) begin
      for (int i = 0; i < NCH; i++) begin
        if (global_thr || i == int'(sel_idx)) begin
          st_nxt.thr[i] = thr_wdata;
        end
      end
    end
    case (st_r.state)
      ST_IDLE: begin
        if ((win_mode == acc_pkg::MODE_STROBE && strobe_rise) ||
            (win_mode == acc_pkg::MODE_TIMER && start_req) ||
            (win_mode == acc_pkg::MODE_COUNT)) begin
          st_nxt.state   = ST_RUN;
          st_nxt.sum     = '0;
          st_nxt.nsamp   = 32'h0000_0000;
          st_nxt.win_cnt = 32'h0000_0000;
        end
      end
      ST_RUN: begin
        st_nxt.win_cnt = st_r.win_cnt + 32'h0000_0001;
        if (tick) begin
          st_nxt.nsamp = st_r.nsamp + 32'h0000_0001;
          for (int i = 0; i < NCH; i++) begin
            st_nxt.sum[i] = st_r.sum[i] + SW'(sample_in[i]);
          end
        end
        case (win_mode)
          acc_pkg::MODE_TIMER:  win_end = st_r.win_cnt == WIN_CYCLES - 1;
          acc_pkg::MODE_COUNT:  win_end = tick && st_nxt.nsamp >= 32'(win_count);
          acc_pkg::MODE_STROBE: win_end = !strobe_in;
          default:              win_end = 1'b1;
        endcase
        if (win_end) begin
          if (avg_en) begin
            st_nxt.state  = ST_DIV;
            st_nxt.div_ch = '0;
          end else begin
            st_nxt.state = ST_IDLE;
            st_nxt.done  = 1'b1;
            st_nxt.res   = st_nxt.sum;
            st_nxt.sel_res = st_nxt.sum[sel_idx];
          end
        end else if (live_en && tick) begin
          st_nxt.res     = st_nxt.sum;
          st_nxt.sel_res = st_nxt.sum[sel_idx];
        end
      end
      ST_DIV: begin
        if (div_done) begin
          st_nxt.res[st_r.div_ch] = div_q;
          if (st_r.div_ch == CH_W'(NCH-1)) begin
            st_nxt.state   = ST_IDLE;
            st_nxt.done    = 1'b1;
            st_nxt.sel_res = (st_r.div_ch == sel_idx) ? div_q : st_r.res[sel_idx];
          end else begin
            st_nxt.div_ch = st_r.div_ch + 1'b1;
          end
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active                  = st_r.state != ST_IDLE;
  assign done                    = st_r.done;
  assign strobed_result_store    = st_r.res;
  assign selected_channel_result = st_r.sel_res;
  assign sel_channel             = st_r.sel;
  assign thr_level               = st_r.thr[sel_idx];
  assign threshold_pass_flag     = st_r.pass_d;

  property p_done_ends_active;
    @(posedge clk) disable iff (srst) done |-> $past(st_r.state) != ST_IDLE && !active;
  endproperty
  a_done_ends_active: assert property (p_done_ends_active) else $error("done without window");

  property p_active_state;
    @(posedge clk) disable iff (srst) $rose(active) |-> $past(win_mode == acc_pkg::MODE_COUNT || start_req);
  endproperty
  a_active_state: assert property (p_active_state) else $error("active mismatch");

  property p_mute;
    @(posedge clk) disable iff (srst) $past(mute) |-> !threshold_pass_flag;
  endproperty
  a_mute: assert property (p_mute) else $error("pass while muted");

  property p_latch;
    @(posedge clk) disable iff (srst) done && !$past(avg_en) |-> strobed_result_store == $past(st_nxt.sum);
  endproperty
  a_latch: assert property (p_latch) else $error("result not latched");

  property p_hold;
    @(posedge clk) disable iff (srst) !done && !$past(live_en) && $past(st_r.state) != ST_DIV
      |-> $stable(strobed_result_store);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed outside done");

  property p_sel_write;
    @(posedge clk) disable iff (srst) sel_wr |=> sel_channel == $past(sel_wdata);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select not written");

  property p_thr_write;
    @(posedge clk) disable iff (srst) thr_wr && !sel_wr |=> thr_level == $past(thr_wdata);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold not written");

  property p_global;
    @(posedge clk) disable iff (srst) thr_wr && global_thr |=> st_r.thr[0] == $past(thr_wdata);
  endproperty
  a_global: assert property (p_global) else $error("global threshold not applied");

  property p_pass;
    @(posedge clk) disable iff (srst) threshold_pass_flag == $past(!mute && (thr_below ?
      selected_channel_result < thr_level : selected_channel_result > thr_level));
  endproperty
  a_pass: assert property (p_pass) else $error("pass flag wrong");

  property p_clear;
    @(posedge clk) disable iff (srst) $rose(active) |-> st_r.nsamp == 32'h0000_0000 && st_r.sum == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");

  // Pre-edge sampling means each |=> consequent below is judged one edge after its cause.
  property p_done_pulse;
    @(posedge clk) disable iff (srst) done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_timer_len;
    @(posedge clk) disable iff (srst) done && $past(win_mode == acc_pkg::MODE_TIMER && st_r.state == ST_RUN)
      |-> $past(st_r.win_cnt) == WIN_CYCLES - 1;
  endproperty
  a_timer_len: assert property (p_timer_len) else $error("timed window length wrong");

  property p_count_len;
    @(posedge clk) disable iff (srst)
      done && $past(win_mode == acc_pkg::MODE_COUNT && st_r.state == ST_RUN && win_count != 16'h0000)
      |-> st_r.nsamp == 32'($past(win_count));
  endproperty
  a_count_len: assert property (p_count_len) else $error("counted window length wrong");

  property p_strobe_end;
    @(posedge clk) disable iff (srst) st_r.state == ST_RUN && win_mode == acc_pkg::MODE_STROBE && !strobe_in
      |=> st_r.state != ST_RUN;
  endproperty
  a_strobe_end: assert property (p_strobe_end) else $error("strobe window did not end");

  property p_strobe_start;
    @(posedge clk) disable iff (srst)
      st_r.state == ST_IDLE && win_mode == acc_pkg::MODE_STROBE && strobe_in && !st_r.strobe_d |=> active;
  endproperty
  a_strobe_start: assert property (p_strobe_start) else $error("strobe window did not start");

  property p_strobe_hold;
    @(posedge clk) disable iff (srst) st_r.state == ST_RUN && win_mode == acc_pkg::MODE_STROBE && strobe_in
      |=> st_r.state == ST_RUN;
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe window ended early");

  property p_sw_start;
    @(posedge clk) disable iff (srst) st_r.state == ST_IDLE && win_mode == acc_pkg::MODE_TIMER && sw_strobe
      |=> active;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software strobe ignored");

  property p_timer_idle;
    @(posedge clk) disable iff (srst) st_r.state == ST_IDLE && win_mode == acc_pkg::MODE_TIMER && !sw_strobe &&
      !(strobe_in && !st_r.strobe_d) |=> !active;
  endproperty
  a_timer_idle: assert property (p_timer_idle) else $error("timed window started unasked");

  property p_tick_sum;
    @(posedge clk) disable iff (srst) st_r.state == ST_RUN && tick
      |=> st_r.sum[0] == $past(st_r.sum[0]) + SW'($past(sample_in[0]));
  endproperty
  a_tick_sum: assert property (p_tick_sum) else $error("sample not added on tick");

  property p_no_tick;
    @(posedge clk) disable iff (srst) st_r.state == ST_RUN && !tick |=> $stable(st_r.sum);
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("sum changed between ticks");

  property p_live;
    @(posedge clk) disable iff (srst) live_en && st_r.state == ST_RUN && tick
      |=> strobed_result_store == st_r.sum || st_r.state == ST_DIV;
  endproperty
  a_live: assert property (p_live) else $error("live result not refreshed");

  property p_sel_follow;
    @(posedge clk) disable iff (srst) done && !$past(sel_wr)
      |-> selected_channel_result == strobed_result_store[sel_idx];
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("selected result not chosen channel");

  property p_ev_push;
    @(posedge clk) disable iff (srst) ev_push && ev_ready |=> threshold_event_valid;
  endproperty
  a_ev_push: assert property (p_ev_push) else $error("event not captured");

  property p_ev_hold;
    @(posedge clk) disable iff (srst) threshold_event_valid && !threshold_event_ready
      |=> threshold_event_valid && $stable(threshold_event_store);
  endproperty
  a_ev_hold: assert property (p_ev_hold) else $error("event word not held");

  property p_div_only_avg;
    @(posedge clk) disable iff (srst) st_r.state == ST_DIV && $past(st_r.state) == ST_RUN |-> $past(avg_en);
  endproperty
  a_div_only_avg: assert property (p_div_only_avg) else $error("divide without averaging");

  property p_thr_keep;
    @(posedge clk) disable iff (srst) thr_wr && !global_thr && sel_idx != CH_W'(0)
      |=> st_r.thr[0] == $past(st_r.thr[0]);
  endproperty
  a_thr_keep: assert property (p_thr_keep) else $error("local threshold write spread");

  property p_sel_hold;
    @(posedge clk) disable iff (srst) !sel_wr |=> $stable(sel_channel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed unwritten");

  property p_thr_hold;
    @(posedge clk) disable iff (srst) !thr_wr && !sel_wr |=> $stable(thr_level);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold changed unwritten");
endmodule : signal_window_accumulator

// ===== inc/acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_COUNT,
    MODE_STROBE
  } win_mode_t;
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned WIN_TIME_MS  = 500;
  localparam int unsigned WIN_CYCLES   = WIN_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEF_RATE_DIV = 16'h00C8;
  localparam int unsigned DEF_COUNT    = 16'h0004;
  localparam int unsigned FIFO_DEPTH   = 8;
endpackage : acc_pkg

// ===== tb/acc_partner.sv
`timescale 1ns/1ps
// Stands in for the upstream source and the downstream event consumer.
// Each channel carries a fixed level, channel n giving n+1, so every sum is easy to predict.
module acc_partner #(
  parameter int unsigned NCH = 4,
  parameter int unsigned DW  = 16
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   stall,
  output logic [NCH-1:0][DW-1:0]      sample_out,
  output logic                        event_ready
);
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      sample_out[i] = DW'(i + 1);
    end
  end
  // A slow consumer: it accepts at most every other cycle and not at all while stalled.
  always_ff @(posedge clk) begin
    if (srst || stall) begin
      event_ready <= 1'b0;
    end else begin
      event_ready <= ~event_ready;
    end
  end
endmodule : acc_partner

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int unsigned NCH = 4;
  localparam int unsigned SW  = 32;
  localparam int unsigned WC  = 50;
  logic                    clk, srst, strobe_in, sw_strobe, avg_en, live_en, sel_wr, thr_wr;
  logic                    global_thr, thr_below, mute, capture_en, stall, ev_ready;
  acc_pkg::win_mode_t      win_mode;
  logic [15:0]             win_count, rate_div;
  logic [7:0]              sel_wdata, sel_channel;
  logic [SW-1:0]           thr_wdata, thr_level, sel_res;
  logic [NCH-1:0][15:0]    samples;
  logic [NCH-1:0][SW-1:0]  res;
  logic                    active, done, pass, ev_valid;
  logic [2*SW-1:0]         ev_store;
  int                      fails, checks_done;

  acc_partner #(.NCH(NCH), .DW(16)) u_acc_partner (.clk(clk), .srst(srst), .stall(stall),
    .sample_out(samples), .event_ready(ev_ready));
  signal_window_accumulator #(.NCH(NCH), .DW(16), .SW(SW), .WIN_CYCLES(WC)) u_signal_window_accumulator (
    .clk(clk), .srst(srst), .sample_in(samples), .strobe_in(strobe_in), .sw_strobe(sw_strobe),
    .win_mode(win_mode), .rate_div(rate_div), .win_count(win_count), .avg_en(avg_en), .live_en(live_en),
    .sel_wr(sel_wr), .sel_wdata(sel_wdata), .sel_channel(sel_channel), .thr_wr(thr_wr),
    .thr_wdata(thr_wdata), .thr_level(thr_level), .global_thr(global_thr), .thr_below(thr_below),
    .mute(mute), .capture_en(capture_en), .active(active), .done(done), .strobed_result_store(res),
    .selected_channel_result(sel_res), .threshold_pass_flag(pass), .threshold_event_valid(ev_valid),
    .threshold_event_ready(ev_ready), .threshold_event_store(ev_store));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({63'h0, got}, {63'h0, exp});
  endtask : chk_bit

  // Settled sampling: outputs are read 1 ns after the edge that updates them.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wait_done(output int act_cycles);
    int k;
    act_cycles = 0;
    #1;
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      if (active === 1'b1) act_cycles++;
      cyc(1);
    end
    if (k == 3000) chk_bit(1'b0, 1'b1);
  endtask : wait_done

  task automatic pulse_sw;
    @(posedge clk) sw_strobe <= 1'b1;
    @(posedge clk) sw_strobe <= 1'b0;
    #1;
  endtask : pulse_sw

  task automatic chk_all(input int mult);
    for (int i = 0; i < NCH; i++) chk_val(64'(res[i]), 64'(mult * (i + 1)));
  endtask : chk_all

  task automatic test_timer;
    int n;
    pulse_sw();
    chk_bit(active, 1'b1);
    pulse_sw();
    wait_done(n);
    // The refused second pulse costs two window cycles before counting starts.
    chk_val(64'(n + 2), 64'(WC));
    chk_bit(active, 1'b0);
    chk_all(WC);
  endtask : test_timer

  task automatic test_strobe;
    int n;
    @(posedge clk) win_mode <= acc_pkg::MODE_STROBE;
    @(posedge clk) strobe_in <= 1'b1;
    repeat (20) @(posedge clk);
    strobe_in <= 1'b0;
    wait_done(n);
    chk_all(20);
  endtask : test_strobe

  task automatic test_thr;
    int n;
    @(posedge clk) win_mode <= acc_pkg::MODE_TIMER;
    sel_wr <= 1'b1;
    sel_wdata <= 8'h02;
    @(posedge clk) sel_wr <= 1'b0;
    thr_wr <= 1'b1;
    thr_wdata <= 32'h0000_0064;
    @(posedge clk) thr_wr <= 1'b0;
    capture_en <= 1'b1;
    stall <= 1'b1;
    cyc(1);
    chk_val(64'(sel_channel), 64'h0000_0000_0000_0002);
    chk_val(64'(thr_level), 64'h0000_0000_0000_0064);
    strobe_in <= 1'b1;
    wait_done(n);
    strobe_in <= 1'b0;
    chk_val(64'(sel_res), 64'(WC * 3));
    cyc(3);
    chk_bit(pass, 1'b1);
    chk_bit(ev_valid, 1'b1);
    chk_val(64'(ev_store[SW-1:0]), 64'(WC * 3));
    @(posedge clk) mute <= 1'b1;
    cyc(3);
    chk_bit(pass, 1'b0);
    @(posedge clk) mute <= 1'b0;
    thr_below <= 1'b1;
    cyc(3);
    chk_bit(pass, 1'b0);
    @(posedge clk) thr_wdata <= 32'h0000_0100;
    thr_wr <= 1'b1;
    @(posedge clk) thr_wr <= 1'b0;
    cyc(3);
    chk_bit(pass, 1'b1);
    @(posedge clk) stall <= 1'b0;
    cyc(40);
    chk_bit(ev_valid, 1'b0);
  endtask : test_thr

  task automatic test_live;
    @(posedge clk) live_en <= 1'b1;
    pulse_sw();
    cyc(10);
    chk_bit(sel_res > 0 && sel_res < WC * 3, 1'b1);
    cyc(60);
    @(posedge clk) live_en <= 1'b0;
  endtask : test_live

  task automatic test_global;
    @(posedge clk) global_thr <= 1'b1;
    thr_wr <= 1'b1;
    thr_wdata <= 32'h0000_0010;
    @(posedge clk) thr_wr <= 1'b0;
    sel_wr <= 1'b1;
    sel_wdata <= 8'h00;
    @(posedge clk) sel_wr <= 1'b0;
    cyc(2);
    chk_val(64'(thr_level), 64'h0000_0000_0000_0010);
  endtask : test_global

  task automatic test_count;
    int n;
    @(posedge clk) win_mode <= acc_pkg::MODE_COUNT;
    wait_done(n);
    cyc(1);
    wait_done(n);
    chk_all(4);
    cyc(1);
    wait_done(n);
    chk_all(4);
    // A tick every fourth clock stretches four ticks to thirteen to sixteen clocks.
    @(posedge clk) rate_div <= 16'h0004;
    wait_done(n);
    cyc(1);
    wait_done(n);
    chk_bit(n >= 13 && n <= 16, 1'b1);
    chk_all(4);
    @(posedge clk) avg_en <= 1'b1;
    cyc(1);
    wait_done(n);
    cyc(1);
    wait_done(n);
    chk_all(1);
  endtask : test_count

  initial begin
    srst = 1'b1;
    {strobe_in, sw_strobe, avg_en, live_en, sel_wr, thr_wr, global_thr, thr_below, mute} = '0;
    capture_en = 1'b0;
    stall = 1'b0;
    win_mode = acc_pkg::MODE_TIMER;
    win_count = 16'h0004;
    rate_div = 16'h0001;
    sel_wdata = 8'h00;
    thr_wdata = '0;
    fails = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    cyc(2);
    chk_bit(done, 1'b0);
    test_timer();
    test_strobe();
    test_thr();
    test_live();
    test_global();
    test_count();
    complete_run();
  end

  // The whole run needs several hundred cycles; this bound leaves wide headroom.
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule : testbench
